// ### src/pvic_top.sv
// Process-value conditioning: scaling, gain and shift, moving average, lag filter.
// Assumes raw samples arrive from logic on pclk; settings are written over APB.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module pvic_top
   import pvic_pkg::*;
#(
   parameter int NUM_CH = 2,
   parameter bit ALT_VARIANT = 1'b0,
   parameter logic signed [RAW_W-1:0] RAW_SPAN_MIN = 16'h0000,
   parameter logic signed [RAW_W-1:0] RAW_SPAN_MAX = 16'h2710
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic raw_valid,
   output logic raw_ready,
   input wire pvic_sample_type raw_input_value,
   output logic out_valid,
   input wire logic out_ready,
   output logic [CH_W-1:0] out_channel,
   output logic signed [VAL_W-1:0] corrected_value,
   output logic [1:0] decimal_place_select
);
   localparam logic [2:0] AVG_RST = ALT_VARIANT ? AVG_ALT_RST : AVG_OFF;
   localparam logic [DIV_W-1:0] GAIN_DEN = DIV_W'(GAIN_RST);
   localparam logic [DIV_W-1:0] TS = DIV_W'(SAMPLE_PERIOD_TENTHS);

   // ==========================================
   // Settings
   logic [7:0] input_type;
   logic signed [15:0] pv_offset_value;
   logic [13:0] pv_gain_coefficient;
   logic [2:0] avg_depth [NUM_CH];
   logic [13:0] filter_time;
   logic signed [15:0] scale_high;
   logic signed [15:0] scale_low;
   logic [NUM_CH-1:0] avg_clear;

   // ==========================================
   // Datapath state
   pvic_state_type state;
   pvic_sample_type fifo_data;
   logic fifo_valid;
   logic fifo_pop;
   logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level;
   logic [CH_W-1:0] cur_ch;
   logic signed [VAL_W-1:0] val;
   logic waiting;
   logic neg;
   logic div_start;
   logic [DIV_W-1:0] div_num;
   logic [DIV_W-1:0] div_den;
   logic div_busy;
   logic div_done;
   logic [DIV_W-1:0] div_q;
   logic signed [VAL_W-1:0] div_signed;

   logic signed [VAL_W-1:0] hist [NUM_CH][HIST_DEPTH];
   logic [4:0] hist_ptr [NUM_CH];
   logic [5:0] hist_fill [NUM_CH];
   logic signed [VAL_W+5:0] hist_sum [NUM_CH];
   logic signed [VAL_W-1:0] filt_y [NUM_CH];
   logic [NUM_CH-1:0] filt_primed;

   logic [5:0] depth_n;
   logic [4:0] oldest_idx;
   logic signed [VAL_W+5:0] next_sum;
   logic signed [VAL_W+5:0] mean_shift;
   logic signed [DIV_W-1:0] prod_scale;
   logic signed [DIV_W-1:0] prod_gain;
   logic signed [DIV_W-1:0] prod_filt;
   logic signed [VAL_W-1:0] filt_diff;

   function automatic logic [DIV_W-1:0] mag(input logic signed [DIV_W-1:0] x);
      mag = x[DIV_W-1] ? DIV_W'(-x) : x;
   endfunction

   assign depth_n = 6'h01 << avg_depth[cur_ch];
   assign oldest_idx = 5'(hist_ptr[cur_ch] - depth_n[4:0]);
   assign next_sum = hist_sum[cur_ch] + (VAL_W+6)'(val)
      - ((hist_fill[cur_ch] == depth_n) ? (VAL_W+6)'(hist[cur_ch][oldest_idx]) : '0);
   assign mean_shift = next_sum >>> avg_depth[cur_ch];
   assign prod_scale = DIV_W'(val - VAL_W'(RAW_SPAN_MIN)) * DIV_W'(scale_high - scale_low);
   assign prod_gain = DIV_W'(val) * $signed({1'b0, pv_gain_coefficient});
   assign filt_diff = val - filt_y[cur_ch];
   assign prod_filt = DIV_W'(filt_diff) * $signed(TS);
   assign div_signed = neg ? VAL_W'(-$signed(div_q)) : VAL_W'(div_q);
   assign fifo_pop = fifo_valid && (state == ST_IDLE);

   pvic_fifo #(
      .WIDTH($bits(pvic_sample_type)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(raw_valid),
      .in_ready(raw_ready),
      .in_data(raw_input_value),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data),
      .level(fifo_level)
   );

   pvic_divider #(
      .WIDTH(DIV_W)
   ) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .start(div_start),
      .dividend(div_num),
      .divisor(div_den),
      .busy(div_busy),
      .done(div_done),
      .quotient(div_q)
   );

   // ==========================================
   // APB slave, no wait states; pready is high in the first access cycle
   logic access;
   logic [31:0] rd_word;
   logic rd_err;

   assign access = psel && penable && pready;

   always_comb
   begin
      rd_word = '0;
      rd_err = 1'b0;
      if (paddr == OFS_INPUT_TYPE)
         rd_word = 32'(input_type);
      else if (paddr == OFS_SHIFT)
         rd_word = 32'(pv_offset_value);
      else if (paddr == OFS_GAIN)
         rd_word = 32'(pv_gain_coefficient);
      else if (paddr == OFS_AVG_DEPTH)
      begin
         for (int c = 0; c < NUM_CH; c++)
            rd_word[c*AVG_FIELD_W +: 3] = avg_depth[c];
      end
      else if (paddr == OFS_FILTER_TIME)
         rd_word = 32'(filter_time);
      else if (paddr == OFS_SCALE_HIGH)
         rd_word = 32'(scale_high);
      else if (paddr == OFS_SCALE_LOW)
         rd_word = 32'(scale_low);
      else if (paddr == OFS_DECIMAL)
         rd_word = 32'(decimal_place_select);
      else if (paddr == OFS_STATUS)
         rd_word = {fifo_level[3:0], state, filt_primed[0], corrected_value};
      else
         rd_err = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable && !pready;
         pslverr <= psel && !penable && rd_err;
         if (psel && !penable && !pwrite)
            prdata <= rd_word;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         input_type <= INPUT_TYPE_RST;
         pv_offset_value <= SHIFT_RST;
         pv_gain_coefficient <= GAIN_RST;
         filter_time <= FILTER_RST;
         scale_high <= SCALE_HIGH_RST;
         scale_low <= SCALE_LOW_RST;
         decimal_place_select <= DECIMAL_RST;
         avg_clear <= '0;
         for (int c = 0; c < NUM_CH; c++)
            avg_depth[c] <= AVG_RST;
      end
      else
      begin
         avg_clear <= '0;
         if (access && pwrite && !pslverr)
         begin
            if (paddr == OFS_INPUT_TYPE)
               input_type <= pwdata[7:0];
            else if (paddr == OFS_SHIFT)
            begin
               // Same integer range covers tenths of a degree and whole units
               if ($signed(pwdata) >= 32'(SHIFT_MIN) && $signed(pwdata) <= 32'(SHIFT_MAX))
                  pv_offset_value <= pwdata[15:0];
            end
            else if (paddr == OFS_GAIN)
            begin
               if (pwdata >= 32'(GAIN_MIN) && pwdata <= 32'(GAIN_MAX))
                  pv_gain_coefficient <= pwdata[13:0];
            end
            else if (paddr == OFS_AVG_DEPTH)
            begin
               for (int c = 0; c < NUM_CH; c++)
               begin
                  if (pwdata[c*AVG_FIELD_W +: 3] <= AVG_MAX)
                  begin
                     avg_depth[c] <= pwdata[c*AVG_FIELD_W +: 3];
                     avg_clear[c] <= 1'b1;
                  end
               end
            end
            else if (paddr == OFS_FILTER_TIME)
            begin
               if (pwdata <= 32'(FILTER_MAX))
                  filter_time <= pwdata[13:0];
            end
            else if (paddr == OFS_SCALE_HIGH)
               scale_high <= pwdata[15:0];
            else if (paddr == OFS_SCALE_LOW)
               scale_low <= pwdata[15:0];
            else if (paddr == OFS_DECIMAL)
            begin
               if (pwdata <= 32'(DECIMAL_MAX))
                  decimal_place_select <= pwdata[1:0];
            end
         end
      end
   end

   // ==========================================
   // Conditioning sequence
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= ST_IDLE;
         cur_ch <= '0;
         val <= '0;
         waiting <= 1'b0;
         neg <= 1'b0;
         div_start <= 1'b0;
         div_num <= '0;
         div_den <= '0;
         out_valid <= 1'b0;
         out_channel <= '0;
         corrected_value <= '0;
      end
      else
      begin
         div_start <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               if (fifo_valid)
               begin
                  cur_ch <= fifo_data.channel;
                  val <= VAL_W'(fifo_data.value);
                  state <= ST_SCALE;
               end
            end
            ST_SCALE:
            begin
               if (input_type != INPUT_TYPE_ANALOG)
                  state <= ST_GAIN;
               else if (!waiting)
               begin
                  div_num <= mag(prod_scale);
                  div_den <= DIV_W'(RAW_SPAN_MAX - RAW_SPAN_MIN);
                  neg <= prod_scale[DIV_W-1];
                  div_start <= 1'b1;
                  waiting <= 1'b1;
               end
               else if (div_done)
               begin
                  val <= div_signed + VAL_W'(scale_low);
                  waiting <= 1'b0;
                  state <= ST_GAIN;
               end
            end
            ST_GAIN:
            begin
               if (!waiting)
               begin
                  div_num <= mag(prod_gain);
                  div_den <= GAIN_DEN;
                  neg <= prod_gain[DIV_W-1];
                  div_start <= 1'b1;
                  waiting <= 1'b1;
               end
               else if (div_done)
               begin
                  val <= div_signed + VAL_W'(pv_offset_value);
                  waiting <= 1'b0;
                  state <= ST_AVG;
               end
            end
            ST_AVG:
            begin
               // Until N-1 samples are held the sample passes through
               if (avg_depth[cur_ch] != AVG_OFF && hist_fill[cur_ch] >= 6'(depth_n - 1'b1))
                  val <= VAL_W'(mean_shift);
               state <= ST_FILT;
            end
            ST_FILT:
            begin
               if (filter_time == '0 || !filt_primed[cur_ch])
                  state <= ST_OUT;
               else if (!waiting)
               begin
                  div_num <= mag(prod_filt);
                  div_den <= DIV_W'(filter_time) + TS;
                  neg <= prod_filt[DIV_W-1];
                  div_start <= 1'b1;
                  waiting <= 1'b1;
               end
               else if (div_done)
               begin
                  val <= filt_y[cur_ch] + div_signed;
                  waiting <= 1'b0;
                  state <= ST_OUT;
               end
            end
            ST_OUT:
            begin
               if (!out_valid)
               begin
                  out_valid <= 1'b1;
                  out_channel <= cur_ch;
                  corrected_value <= val;
               end
               else if (out_ready)
               begin
                  out_valid <= 1'b0;
                  state <= ST_IDLE;
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // ==========================================
   // Averaging history, updated as ST_AVG leaves
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            hist_ptr[c] <= '0;
            hist_fill[c] <= '0;
            hist_sum[c] <= '0;
            for (int i = 0; i < HIST_DEPTH; i++)
               hist[c][i] <= '0;
         end
      end
      else
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            if (avg_clear[c])
            begin
               hist_fill[c] <= '0;
               hist_sum[c] <= '0;
            end
            else if (state == ST_AVG && cur_ch == CH_W'(c) && avg_depth[c] != AVG_OFF)
            begin
               hist[c][hist_ptr[c]] <= val;
               hist_ptr[c] <= 5'(hist_ptr[c] + 1'b1);
               hist_sum[c] <= next_sum;
               if (hist_fill[c] != depth_n)
                  hist_fill[c] <= hist_fill[c] + 1'b1;
            end
         end
      end
   end

   // ==========================================
   // Lag filter memory, one per channel
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         filt_primed <= '0;
         for (int c = 0; c < NUM_CH; c++)
            filt_y[c] <= '0;
      end
      else if (state == ST_OUT && !out_valid)
      begin
         filt_y[cur_ch] <= val;
         filt_primed[cur_ch] <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ### shared/pvic_pkg.sv
// Constants, register map and carrier types of the process-value input conditioning path.
// Assumes a single pclk domain and an APB master that follows the usual two-phase protocol.
//
// Contract
// - Temperature input shift accepted from -199.9 to 999.9 degrees, default 0.0.
// - Analog input shift accepted from -1999 to 9999 units, default zero.
// - Gain held with three decimals, 0.001 to 9.999, reset value 1.000.
// - Corrected value is raw times gain, then plus shift.
// - Averaging depth is off, 2, 4, 8, 16 or 32; off passes samples.
// - Averaging depth held separately for each input channel.
// - Averaging depth resets to off, or to 8 on the other variant.
// - Filter time 0.0 to 999.9 s, default 0.0; zero bypasses the filter.
// - Analog input span maps linearly onto lower to upper scaling limits.
// - Input type resets to code 5; code 25 selects scaled current input.
// - Upper scaling limit resets to 100, read with the decimal point.
// - Decimal point resets to 0; 1 gives one fractional digit.
package pvic_pkg;

   localparam int RAW_W = 16;
   localparam int VAL_W = 24;
   localparam int DIV_W = 48;
   localparam int CH_W = 1;
   localparam int FIFO_DEPTH = 16;
   localparam int HIST_DEPTH = 32;

   // Register byte offsets
   localparam logic [7:0] OFS_INPUT_TYPE = 8'h00;
   localparam logic [7:0] OFS_SHIFT = 8'h04;
   localparam logic [7:0] OFS_GAIN = 8'h08;
   localparam logic [7:0] OFS_AVG_DEPTH = 8'h0c;
   localparam logic [7:0] OFS_FILTER_TIME = 8'h10;
   localparam logic [7:0] OFS_SCALE_HIGH = 8'h14;
   localparam logic [7:0] OFS_SCALE_LOW = 8'h18;
   localparam logic [7:0] OFS_DECIMAL = 8'h1c;
   localparam logic [7:0] OFS_STATUS = 8'h20;

   // Reset values and limits
   localparam logic [7:0] INPUT_TYPE_RST = 8'h05;
   localparam logic [7:0] INPUT_TYPE_ANALOG = 8'h19;
   localparam logic signed [15:0] SHIFT_RST = 16'h0000;
   localparam logic signed [15:0] SHIFT_MIN = 16'hf831;
   localparam logic signed [15:0] SHIFT_MAX = 16'h270f;
   localparam logic [13:0] GAIN_RST = 14'h03e8;
   localparam logic [13:0] GAIN_MIN = 14'h0001;
   localparam logic [13:0] GAIN_MAX = 14'h270f;
   localparam logic [13:0] FILTER_RST = 14'h0000;
   localparam logic [13:0] FILTER_MAX = 14'h270f;
   localparam logic signed [15:0] SCALE_HIGH_RST = 16'h0064;
   localparam logic signed [15:0] SCALE_LOW_RST = 16'h0000;
   localparam logic [1:0] DECIMAL_RST = 2'h0;
   localparam logic [1:0] DECIMAL_MAX = 2'h3;

   // Averaging depth codes: depth is 2 to the power of the code
   localparam logic [2:0] AVG_OFF = 3'h0;
   localparam logic [2:0] AVG_MAX = 3'h5;
   localparam logic [2:0] AVG_ALT_RST = 3'h3;
   localparam int AVG_FIELD_W = 4;

   // Filter sample period, tenths of a second
   localparam int SAMPLE_PERIOD_TENTHS = 1;

   typedef struct packed {
      logic [CH_W-1:0] channel;
      logic signed [RAW_W-1:0] value;
   } pvic_sample_type;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SCALE,
      ST_GAIN,
      ST_AVG,
      ST_FILT,
      ST_OUT
   } pvic_state_type;

endpackage

// ### src/pvic_fifo.sv
// Synchronous FIFO holding raw samples ahead of the conditioning datapath.
// Assumes both sides on pclk; ready and valid follow the usual handshake.
`timescale 1ns/100ps
`default_nettype none
module pvic_fifo
#(
   parameter int WIDTH = 17,
   parameter int DEPTH = 16
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic push;
   logic pop;

   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_ptr];

   always_ff @(posedge pclk)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= AW'(wr_ptr + 1'b1);
         end
         if (pop)
         begin
            rd_ptr <= AW'(rd_ptr + 1'b1);
         end
         if (push && !pop)
         begin
            level <= level + 1'b1;
            in_ready <= (level != ($bits(level))'(DEPTH - 1));
            out_valid <= 1'b1;
         end
         else if (pop && !push)
         begin
            level <= level - 1'b1;
            in_ready <= 1'b1;
            out_valid <= (level != ($bits(level))'(1));
         end
         else
         begin
            in_ready <= (level != ($bits(level))'(DEPTH));
            out_valid <= (level != '0);
         end
      end
   end
endmodule
`default_nettype wire

// ### src/pvic_divider.sv
// Unsigned restoring divider, one quotient bit per cycle.
// Assumes start is a one-cycle pulse given only while busy is low.
`timescale 1ns/100ps
`default_nettype none
module pvic_divider
#(
   parameter int WIDTH = 48
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic [WIDTH-1:0] dividend,
   input wire logic [WIDTH-1:0] divisor,
   output logic busy,
   output logic done,
   output logic [WIDTH-1:0] quotient
);
   logic [WIDTH-1:0] rem;
   logic [WIDTH-1:0] den;
   logic [$clog2(WIDTH+1)-1:0] count;
   logic [WIDTH:0] trial;

   assign trial = {rem, quotient[WIDTH-1]} - {1'b0, den};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rem <= '0;
         den <= '0;
         count <= '0;
         quotient <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start && !busy)
         begin
            rem <= '0;
            den <= divisor;
            quotient <= dividend;
            count <= ($bits(count))'(WIDTH);
            busy <= 1'b1;
         end
         else if (busy)
         begin
            if (!trial[WIDTH])
            begin
               rem <= trial[WIDTH-1:0];
               quotient <= {quotient[WIDTH-2:0], 1'b1};
            end
            else
            begin
               rem <= {rem[WIDTH-2:0], quotient[WIDTH-1]};
               quotient <= {quotient[WIDTH-2:0], 1'b0};
            end
            count <= count - 1'b1;
            if (count == ($bits(count))'(1))
            begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### verif/pvic_assertions.sv
// Port checker for pvic_top.
// Assumes one pclk domain and a bind to every pvic_top.
`timescale 1ns/100ps
`default_nettype none
module pvic_assertions
   import pvic_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire logic [CH_W-1:0] out_channel,
   input wire logic signed [VAL_W-1:0] corrected_value,
   input wire logic [1:0] decimal_place_select
);
   // ====
   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_ready;
      psel && !penable |=> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("pready late");
   property p_one;
      pready |=> !pready;
   endproperty
   a_one: assert property (p_one) else $error("pready too long");
   property p_err;
      pslverr |-> pready;
   endproperty
   a_err: assert property (p_err) else $error("pslverr alone");
   property p_hold;
      out_valid && !out_ready |=> out_valid && $stable(corrected_value) && $stable(out_channel);
   endproperty
   a_hold: assert property (p_hold) else $error("result dropped");
   property p_dp;
      $changed(decimal_place_select) |-> $past(pwrite) && $past(penable) && $past(paddr) == OFS_DECIMAL;
   endproperty
   a_dp: assert property (p_dp) else $error("decimal moved");
   property p_dpval;
      psel && penable && pready && pwrite && paddr == OFS_DECIMAL && pwdata[31:2] == 30'h0
         |=> decimal_place_select == $past(pwdata[1:0]);
   endproperty
   a_dpval: assert property (p_dpval) else $error("decimal not taken");
   property p_unm;
      psel && !penable && paddr > 8'h23 |=> pslverr;
   endproperty
   a_unm: assert property (p_unm) else $error("no pslverr");
   property p_rd0;
      pslverr && !pwrite |-> prdata == 32'h0;
   endproperty
   a_rd0: assert property (p_rd0) else $error("unmapped data");
endmodule
bind pvic_top pvic_assertions u_pvic_assertions (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .out_valid(out_valid), .out_ready(out_ready),
   .out_channel(out_channel), .corrected_value(corrected_value),
   .decimal_place_select(decimal_place_select));
`default_nettype wire

// ### verif/pvic_source.sv
// Raw sample source in place of the input converter.
// Assumes the sink takes a sample at a pclk edge with ready high.
`timescale 1ns/100ps
`default_nettype none
module pvic_source
   import pvic_pkg::*;
(
   input wire logic pclk,
   input wire logic raw_ready,
   output logic raw_valid,
   output pvic_sample_type raw_input_value
);
   // ====
   // Driver
   initial
   begin
      raw_valid = 1'b0;
      raw_input_value = '0;
   end
   task send(input logic [CH_W-1:0] ch, input logic signed [RAW_W-1:0] v);
      @(posedge pclk);
      raw_valid <= 1'b1;
      raw_input_value <= '{ch, v};
      do
         @(posedge pclk);
      while (raw_ready !== 1'b1);
      raw_valid <= 1'b0;
      // Idle data scrambled
      raw_input_value <= pvic_sample_type'(~raw_input_value);
   endtask
endmodule
`default_nettype wire

// ### verif/pvic_top_tb.sv
// Self-checking bench of pvic_top.
// Assumes pvic_source as sample feed and the bound port checker.
`timescale 1ns/100ps
`default_nettype none
module pvic_top_tb
   import pvic_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic out_ready = 1'b1;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er, raw_valid, raw_ready, out_valid;
   pvic_sample_type raw_input_value;
   logic [CH_W-1:0] out_channel, lc;
   logic signed [VAL_W-1:0] corrected_value;
   logic [1:0] decimal_place_select;
   int err_count = 0;
   int n_compared = 0;
   always #5 pclk = ~pclk;
   pvic_top u_pvic_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .raw_valid(raw_valid), .raw_ready(raw_ready),
      .raw_input_value(raw_input_value), .out_valid(out_valid), .out_ready(out_ready),
      .out_channel(out_channel), .corrected_value(corrected_value),
      .decimal_place_select(decimal_place_select));
   pvic_source u_pvic_source (.pclk(pclk), .raw_ready(raw_ready), .raw_valid(raw_valid),
      .raw_input_value(raw_input_value));
   // ====
   // Helpers
   task end_sim;
      if (err_count == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task put(input logic [CH_W-1:0] c, input logic signed [RAW_W-1:0] v);
      lc = c;
      u_pvic_source.send(c, v);
   endtask
   task get(input logic [23:0] e);
      do
         @(posedge pclk);
      while (!(out_valid === 1'b1 && out_ready === 1'b1));
      chk({7'h0, out_channel, corrected_value}, {7'h0, lc, e});
   endtask
   // ====
   // Scenarios
   task t_reset;
      rc(OFS_INPUT_TYPE, 32'h5);
      rc(OFS_SHIFT, 32'h0);
      rc(OFS_GAIN, 32'h3e8);
      rc(OFS_AVG_DEPTH, 32'h0);
      rc(OFS_FILTER_TIME, 32'h0);
      rc(OFS_SCALE_HIGH, 32'h64);
      rc(OFS_DECIMAL, 32'h0);
      rc(8'h40, 32'h0);
      chk({31'h0, er}, 32'h1);
   endtask
   task t_limits;
      wr(OFS_GAIN, 32'h0);
      rc(OFS_GAIN, 32'h3e8);
      wr(OFS_GAIN, 32'h2710);
      rc(OFS_GAIN, 32'h3e8);
      wr(OFS_SHIFT, 32'hfffff831);
      rc(OFS_SHIFT, 32'hfffff831);
      wr(OFS_SHIFT, 32'hfffff830);
      rc(OFS_SHIFT, 32'hfffff831);
      wr(OFS_SHIFT, 32'h270f);
      rc(OFS_SHIFT, 32'h270f);
      wr(OFS_FILTER_TIME, 32'h2710);
      rc(OFS_FILTER_TIME, 32'h0);
      for (int c = 1; c <= 6; c++)
      begin
         wr(OFS_AVG_DEPTH, 32'(c));
         rc(OFS_AVG_DEPTH, (c == 6) ? 32'h5 : 32'(c));
      end
      wr(OFS_AVG_DEPTH, 32'h0);
   endtask
   task t_gain;
      wr(OFS_GAIN, 32'h348);
      wr(OFS_SHIFT, 32'h82);
      put(1'b0, 16'sd500);
      get(24'd550);
      put(1'b0, 16'sd1000);
      get(24'd970);
      wr(OFS_GAIN, 32'h3e8);
      wr(OFS_SHIFT, 32'h0);
   endtask
   task t_filt;
      wr(OFS_FILTER_TIME, 32'h1);
      put(1'b1, 16'sd100);
      get(24'd100);
      put(1'b1, 16'sd300);
      get(24'd200);
      put(1'b1, 16'sd300);
      get(24'd250);
      wr(OFS_FILTER_TIME, 32'h0);
      put(1'b1, 16'sd40);
      get(24'd40);
   endtask
   task t_avg;
      wr(OFS_AVG_DEPTH, 32'h1);
      put(1'b0, 16'sd100);
      get(24'd100);
      put(1'b0, 16'sd300);
      get(24'd200);
      put(1'b1, 16'sd300);
      get(24'd300);
      wr(OFS_AVG_DEPTH, 32'h0);
   endtask
   task t_scale;
      wr(OFS_INPUT_TYPE, 32'h19);
      wr(OFS_SCALE_HIGH, 32'h3b6);
      wr(OFS_SCALE_LOW, 32'h64);
      put(1'b0, 16'sd5000);
      get(24'd525);
      put(1'b0, 16'sd10000);
      get(24'd950);
      wr(OFS_INPUT_TYPE, 32'h5);
      put(1'b0, 16'sd5000);
      get(24'd5000);
   endtask
   task t_dec;
      wr(OFS_DECIMAL, 32'h1);
      @(posedge pclk);
      chk({30'h0, decimal_place_select}, 32'h1);
      wr(OFS_DECIMAL, 32'h4);
      rc(OFS_DECIMAL, 32'h1);
   endtask
   task t_fifo;
      int n;
      n = 0;
      out_ready <= 1'b0;
      while (n < 20)
      begin
         @(posedge pclk);
         if (raw_ready !== 1'b1)
            break;
         put(1'b0, 16'(n + 20));
         n++;
      end
      chk(32'(n), FIFO_DEPTH + 1);
      out_ready <= 1'b1;
      for (int i = 0; i < n; i++)
         get(24'(i + 20));
   endtask
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_limits;
      t_gain;
      t_filt;
      t_avg;
      t_scale;
      t_dec;
      t_fifo;
      end_sim;
   end
   initial
   begin
      #500000;
      err_count++;
      end_sim;
   end
endmodule
`default_nettype wire
